// ---- shared/gcl_pkg.sv ----
package gcl_pkg;
  typedef enum logic [2:0] {
    ARM_IDLE, ARM_W1, ARM_W0, ARM_W1B, ARM_R0
  } gcl_arm_t;
  typedef enum logic [1:0] {
    FN_GP_PP = 2'b00, FN_GP_OD = 2'b01, FN_AF_PP = 2'b10, FN_AF_OD = 2'b11
  } gcl_func_t;
endpackage : gcl_pkg

// ---- shared/gcl_regs.svh ----
// Notes on behaviour
// - lock register bits 15:0 each lock one pin's configuration when set.
// - per-pin lock bits are writable only while the key bit is zero.
// - bit 16 is the key; once one, register frozen until reset.
// - arming order: write key 1, 0, 1, then read 0, then read 1.
// - lock bits must not change during arming; any error prevents arming.
// - every read returns the current key state.
// - once armed, mode and function of locked pins cannot change until reset.
// - alternate output pins are driven by the peripheral, not the output register.
// - an inactive peripheral leaves its alternate output pin undriven.
// - alternate output supports push-pull and open-drain drive.
// - alternate input behaves as general input; pulls follow the input-mode function field.
// - a pin carries only one function at a time.
// - function 10 is alternate push-pull, 11 alternate open-drain; mode 00 is input.
`ifndef GCL_REGS_SVH
`define GCL_REGS_SVH
`define GCL_CFG_LO_OFF 8'h00
`define GCL_CFG_HI_OFF 8'h04
`define GCL_IDATA_OFF 8'h08
`define GCL_ODATA_OFF 8'h0c
`define GCL_LOCK_OFF 8'h18
`define GCL_CFG_RESET 32'h44444444
`define GCL_LOCK_KEY_BIT 16
`define GCL_AXI_OKAY 2'b00
`define GCL_AXI_SLVERR 2'b10
`endif

// ---- src/gcl_pin_mux.sv ----
`timescale 1ns/10ps
// per-pin pad control from mode/function fields
module gcl_pin_mux (
  input wire logic [3:0] cfg,
  input wire logic port_output_bit,
  input wire logic af_out,
  input wire logic af_active,
  output logic pad_out,
  output logic pad_oe,
  output logic pu_pd_en,
  output logic af_sel
);
  wire is_out = cfg[1:0] != 2'b00;
  wire [1:0] fn = cfg[3:2];
  wire is_af = is_out && fn[1];
  wire od = fn[0];
  wire src = is_af ? af_out : port_output_bit;
  wire drv_ok = is_out && (!is_af || af_active);
  assign af_sel = is_af;
  assign pad_out = src;
  assign pad_oe = drv_ok && (!od || !src);
  assign pu_pd_en = !is_out && fn == 2'b10;
endmodule : gcl_pin_mux

// ---- src/gcl_port_lock.sv ----
`timescale 1ns/10ps
`include "gcl_regs.svh"
module gcl_port_lock #(
  parameter int NPINS = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] af_out,
  input wire logic [NPINS-1:0] af_active,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_pull_en,
  output logic [NPINS-1:0] af_in,
  output logic [NPINS-1:0] af_sel
);
  logic [63:0] cfg_q;
  logic [NPINS-1:0] odata_q;
  logic [NPINS-1:0] pin_lock_bit_q;
  logic lock_arm_key_q;
  gcl_pkg::gcl_arm_t arm_q, arm_d;
  logic [NPINS-1:0] sync1_q, sync2_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [NPINS-1:0] pad_out_w, pad_oe_w, pull_w, sel_w;

  // address/data capture in either order
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got_q || aw_hs;
  wire w_have = w_got_q || w_hs;
  wire [7:0] wa = aw_got_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_got_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_got_q ? wstrb_q : s_axi_wstrb;
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire ar_hs = s_axi_arvalid && s_axi_arready;

  wire wr_cfg_lo = wr_fire && wa == `GCL_CFG_LO_OFF;
  wire wr_cfg_hi = wr_fire && wa == `GCL_CFG_HI_OFF;
  wire wr_odata = wr_fire && wa == `GCL_ODATA_OFF;
  wire wr_lock = wr_fire && wa == `GCL_LOCK_OFF && ws == 4'hf;
  wire wr_known = wr_fire && (wa == `GCL_CFG_LO_OFF || wa == `GCL_CFG_HI_OFF ||
    wa == `GCL_ODATA_OFF || wa == `GCL_LOCK_OFF);
  wire rd_lock = ar_hs && s_axi_araddr == `GCL_LOCK_OFF;
  wire wkey = wd[`GCL_LOCK_KEY_BIT];
  wire lock_same = wd[NPINS-1:0] == pin_lock_bit_q;

  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // per-pin guard: locked pins keep their 4-bit nibble once armed
  function automatic logic [31:0] guard(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [7:0] lk, input logic armed);
    logic [31:0] r;
    r = nw;
    for (int i = 0; i < 8; i++) begin
      if (armed && lk[i]) r[i*4 +: 4] = old[i*4 +: 4];
    end
    return r;
  endfunction : guard

  wire [31:0] cfg_lo_d = guard(cfg_q[31:0], merge(cfg_q[31:0], wd, ws),
    pin_lock_bit_q[7:0], lock_arm_key_q);
  wire [31:0] cfg_hi_d = guard(cfg_q[63:32], merge(cfg_q[63:32], wd, ws),
    pin_lock_bit_q[15:8], lock_arm_key_q);
  wire [31:0] odata_m = merge(32'(odata_q), wd, ws);

  // arming sequence detector
  always_comb begin
    arm_d = arm_q;
    if (lock_arm_key_q) begin
      arm_d = gcl_pkg::ARM_IDLE;
    end else if (wr_lock) begin
      unique case (arm_q)
        gcl_pkg::ARM_IDLE: arm_d = wkey ? gcl_pkg::ARM_W1 : gcl_pkg::ARM_IDLE;
        gcl_pkg::ARM_W1: arm_d = (!wkey && lock_same) ? gcl_pkg::ARM_W0 :
          (wkey ? gcl_pkg::ARM_W1 : gcl_pkg::ARM_IDLE);
        gcl_pkg::ARM_W0: arm_d = (wkey && lock_same) ? gcl_pkg::ARM_W1B :
          gcl_pkg::ARM_IDLE;
        gcl_pkg::ARM_W1B: arm_d = wkey ? gcl_pkg::ARM_W1 : gcl_pkg::ARM_IDLE;
        gcl_pkg::ARM_R0: arm_d = wkey ? gcl_pkg::ARM_W1 : gcl_pkg::ARM_IDLE;
      endcase
    end else if (rd_lock) begin
      arm_d = (arm_q == gcl_pkg::ARM_W1B) ? gcl_pkg::ARM_R0 : gcl_pkg::ARM_IDLE;
    end
  end

  // key rises on the read that returns zero after the three writes
  wire key_set = !lock_arm_key_q && rd_lock && arm_q == gcl_pkg::ARM_W1B;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= gcl_pkg::ARM_IDLE;
      lock_arm_key_q <= 1'b0;
    end else begin
      arm_q <= arm_d;
      if (key_set) lock_arm_key_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_lock_bit_q <= '0;
    end else if (wr_lock && !lock_arm_key_q && arm_q == gcl_pkg::ARM_IDLE) begin
      pin_lock_bit_q <= wd[NPINS-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= {`GCL_CFG_RESET, `GCL_CFG_RESET};
      odata_q <= '0;
    end else begin
      if (wr_cfg_lo) cfg_q[31:0] <= cfg_lo_d;
      if (wr_cfg_hi) cfg_q[63:32] <= cfg_hi_d;
      if (wr_odata) odata_q <= odata_m[NPINS-1:0];
    end
  end

  // write channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GCL_AXI_OKAY;
    end else begin
      if (aw_hs) awaddr_q <= s_axi_awaddr;
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `GCL_AXI_OKAY : `GCL_AXI_SLVERR;
      end else begin
        if (aw_hs) aw_got_q <= 1'b1;
        if (w_hs) w_got_q <= 1'b1;
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;

  // read channel
  wire [7:0] ra = s_axi_araddr;
  wire ra_known = ra == `GCL_CFG_LO_OFF || ra == `GCL_CFG_HI_OFF ||
    ra == `GCL_IDATA_OFF || ra == `GCL_ODATA_OFF || ra == `GCL_LOCK_OFF;
  wire [31:0] rd_mux =
    ra == `GCL_CFG_LO_OFF ? cfg_q[31:0] :
    ra == `GCL_CFG_HI_OFF ? cfg_q[63:32] :
    ra == `GCL_IDATA_OFF ? 32'(sync2_q) :
    ra == `GCL_ODATA_OFF ? 32'(odata_q) :
    ra == `GCL_LOCK_OFF ? {15'h0000, lock_arm_key_q, pin_lock_bit_q} : 32'h00000000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `GCL_AXI_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= ra_known ? `GCL_AXI_OKAY : `GCL_AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // pad inputs synchronised
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    gcl_pin_mux u_mux (
      .cfg(cfg_q[p*4 +: 4]),
      .port_output_bit(odata_q[p]),
      .af_out(af_out[p]),
      .af_active(af_active[p]),
      .pad_out(pad_out_w[p]),
      .pad_oe(pad_oe_w[p]),
      .pu_pd_en(pull_w[p]),
      .af_sel(sel_w[p])
    );
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pull_en <= '0;
      af_sel <= '0;
      af_in <= '0;
    end else begin
      pin_out <= pad_out_w;
      pin_oe <= pad_oe_w;
      pin_pull_en <= pull_w & ~sel_w;
      af_sel <= sel_w;
      af_in <= sync2_q;
    end
  end
endmodule : gcl_port_lock

// ---- verif/gcl_port_lock_properties.sv ----
`timescale 1ns/10ps
module gcl_port_lock_properties #(
  parameter int NPINS = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPINS-1:0] af_out,
  input wire logic [NPINS-1:0] af_active,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pin_pull_en,
  input wire logic [NPINS-1:0] af_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence af0_held;
    af_sel[0] && $past(af_sel[0]);
  endsequence
  write_answer_a: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write answer missing");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  unmapped_read_a: assert property (rd_taken ##0 (s_axi_araddr == 8'h40)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answer");
  accept_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  read_single_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  af_drive_a: assert property (
    af0_held ##0 (pin_oe[0] && $stable(af_out[0])) |-> pin_out[0] == af_out[0])
    else $error("alternate pin not driven by peripheral");
  af_idle_a: assert property (af0_held ##0 !$past(af_active[0]) |-> !pin_oe[0])
    else $error("inactive peripheral pin driven");
  af_nopull_a: assert property ((af_sel & pin_pull_en) == '0)
    else $error("pull enabled on alternate pin");
endmodule : gcl_port_lock_properties
bind gcl_port_lock gcl_port_lock_properties #(.NPINS(NPINS)) u_props (
  .mclk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .af_out, .af_active, .pin_out,
  .pin_oe, .pin_pull_en, .af_sel
);

// ---- verif/gpio_config_lock_and_af_routing_tb.sv ----
`timescale 1ns/10ps
`include "gcl_regs.svh"
module gpio_config_lock_and_af_routing_tb;
  logic mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [15:0] pin_in, af_out, af_active, pin_out, pin_oe, pin_pull_en, af_in, af_sel;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  gcl_port_lock #(.NPINS(16)) dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .af_out, .af_active, .pin_out,
    .pin_oe, .pin_pull_en, .af_in, .af_sel);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    logic [1:0] resp;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      // handshakes judged on settled values, acted on at the next rising edge
      @(negedge mclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid === 1'b1;
      resp = s_axi_bresp;
      @(posedge mclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!b_t);
    chk(32'(resp), 32'(`GCL_AXI_OKAY));
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic ar_t, r_t;
    logic [31:0] data;
    logic [1:0] resp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge mclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid === 1'b1;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge mclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!r_t);
    chk(data, exp);
    chk(32'(resp), 32'(a == 8'h40 ? `GCL_AXI_SLVERR : `GCL_AXI_OKAY));
  endtask : rchk
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : do_reset
  task automatic arm(input logic [31:0] bits);
    wr(`GCL_LOCK_OFF, bits | 32'h10000);
    wr(`GCL_LOCK_OFF, bits);
    wr(`GCL_LOCK_OFF, bits | 32'h10000);
    rchk(`GCL_LOCK_OFF, bits);
  endtask : arm
  task automatic t_reset_map();
    rchk(`GCL_LOCK_OFF, 32'h0);
    rchk(`GCL_CFG_LO_OFF, `GCL_CFG_RESET);
    rchk(8'h40, 32'h0);
  endtask : t_reset_map
  task automatic t_af_route();
    wr(`GCL_ODATA_OFF, 32'h1);
    wr(`GCL_CFG_LO_OFF, 32'h444448d9);
    af_active <= 16'h3;
    pin_in <= 16'h4;
    repeat (4) @(posedge mclk);
    chk(32'({pin_oe[2:0], pin_out[0], pin_pull_en[2:0], af_sel[2:0], af_in[2]}),
      32'h347);
    chk(32'(af_in[1]), 32'h0);
    af_out <= 16'h3;
    repeat (3) @(posedge mclk);
    chk(32'({pin_oe[1:0], pin_out[0]}), 32'h3);
    af_out <= 16'h0;
    af_active <= 16'h2;
    repeat (3) @(posedge mclk);
    chk(32'(pin_oe[1:0]), 32'h2);
  endtask : t_af_route
  task automatic t_bad_arm();
    wr(`GCL_LOCK_OFF, 32'h10005);
    wr(`GCL_LOCK_OFF, 32'h7);
    wr(`GCL_LOCK_OFF, 32'h10005);
    rchk(`GCL_LOCK_OFF, 32'h5);
    wr(`GCL_LOCK_OFF, 32'h5);
    wr(`GCL_LOCK_OFF, 32'h10005);
    rchk(`GCL_LOCK_OFF, 32'h5);
    rchk(`GCL_LOCK_OFF, 32'h5);
  endtask : t_bad_arm
  task automatic t_arm_ok();
    arm(32'h5);
    rchk(`GCL_LOCK_OFF, 32'h10005);
    wr(`GCL_LOCK_OFF, 32'hffff);
    rchk(`GCL_LOCK_OFF, 32'h10005);
    wr(`GCL_LOCK_OFF, 32'h0);
    rchk(`GCL_LOCK_OFF, 32'h10005);
    wr(`GCL_CFG_LO_OFF, `GCL_CFG_RESET);
    rchk(`GCL_CFG_LO_OFF, 32'h44444849);
  endtask : t_arm_ok
  task automatic t_rearm();
    do_reset();
    rchk(`GCL_LOCK_OFF, 32'h0);
    arm(32'h1);
    wr(`GCL_LOCK_OFF, 32'h2);
    rchk(`GCL_LOCK_OFF, 32'h10001);
  endtask : t_rearm
  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    {pin_in, af_out, af_active} = 48'h0;
    do_reset();
    t_reset_map();
    t_af_route();
    t_bad_arm();
    t_arm_ok();
    t_rearm();
    test_done();
  end
endmodule : gpio_config_lock_and_af_routing_tb
